// file: hw/gll_lookup_logic.sv
// GPIO lookup logic: truth-table registers and the pins they drive.
//
// Functional notes
// - In upper-A 3-to-1 mode, pin 7 is driven with table 0x25 bit indexed by pins 6..4.
// - In lower-B 3-to-1 mode, pin 11 is driven with table 0x26 bit indexed by pins 10..8.
// - In lower-A 3-to-1 mode, pin 3 is driven with table 0x27 bit indexed by pins 2..0.
// - In lower-B 3-to-2 mode, pin 11 is driven from table 0x28, indexed by pins 10..8.
// - Table bit n gives the output for input pattern n, bit 7 for all high, bit 0 for all low.
// - A table drives its pin only in its matching mode, and every table resets to zero.
// - In lower-B 3-to-2 mode, pin 12 is driven from table 0x2A, indexed by pins 10..8.
//
// Behaviour notes
// Every output is registered, so a pin follows its index pins one clock after they settle.
// The index pins of a table never include the pin that the table drives, so the loop
// through the pad ring closes only through a flip-flop.
// A read and a write to the same table in one cycle return the contents before the write.
// Unmapped addresses read as a fixed word and swallow writes.
// The mode fields are plain inputs; the codes are named in the package enum.
// Lower-A 3-to-2 and every 2-to-1 mode have no table in this block and drive nothing.
// The reset input is released through two flip-flops, so the register port and the
// pins stay quiet for two clocks after it rises.
// Each table is eight bits: bit n answers index pattern n, with pin order kept, so the
// highest index pin is the most significant bit of the pattern.
// The enable output marks the pins that a table owns in the current mode; the pad
// direction logic outside is expected to honour it, and the drive stays low where it is clear.
// Write data lands in a table on the clock after the request and reaches the pins one
// clock later again.
// Nothing here counts or waits: every path from an index pin or mode select to a pin is one clock.
// Mode changes take effect on the next clock, with no handover between tables.
module gll_lookup_logic
  import gll_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rstn,
  // Register access port behind the serial interface.
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [GLL_ADDR_W-1:0] reg_addr,
  input wire logic [GLL_DATA_W-1:0] reg_wdata,
  // Read answer.
  output logic [GLL_DATA_W-1:0] reg_rdata,
  output logic reg_rvalid,
  // Half-bank mode selects.
  input wire logic [1:0] upper_a_logic_mode,
  input wire logic [1:0] lower_a_logic_mode,
  input wire logic [1:0] lower_b_logic_mode,
  // Pin levels in.
  input wire logic [GLL_IO_W-1:0] io_in,
  // Lookup drive out.
  output logic [GLL_IO_W-1:0] io_lut_out,
  output logic [GLL_IO_W-1:0] io_lut_en
);

  typedef struct packed {
    // Truth tables in table order.
    logic [GLL_NUM_LUT-1:0][GLL_DATA_W-1:0] lut;
    // Word captured by the last read.
    logic [GLL_DATA_W-1:0] rdata;
    // One-cycle read answer strobe.
    logic rvalid;
    // Registered pin drive and its ownership mask.
    logic [GLL_IO_W-1:0] pin_out;
    logic [GLL_IO_W-1:0] pin_en;
  } gll_state_s;

  gll_state_s st_q;
  gll_state_s st_d;
  logic [1:0] rst_sync_q;
  logic rst_n;

  // Lookup side: one entry per table.
  logic [GLL_NUM_LUT-1:0] lut_bit;
  logic [GLL_NUM_LUT-1:0][GLL_SEL_W-1:0] lut_sel;
  logic [GLL_NUM_LUT-1:0] lut_live;
  // Register side: address match per table and the word a read would capture.
  logic [GLL_NUM_LUT-1:0] hit;
  logic [GLL_ADDR_W-1:0] lut_ofs [GLL_NUM_LUT];
  logic [GLL_DATA_W-1:0] rd_word;
  // Half-bank modes seen as the enum.
  gll_mode_e upa_mode;
  gll_mode_e lwa_mode;
  gll_mode_e lwb_mode;

  // The reset is released synchronously through two flip-flops.
  // Only the second flop feeds the design, so a late release cannot glitch it.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // Register address of each table.
  assign lut_ofs[GLL_T_UPPER_A_3IN] = GLL_OFS_UPPER_A_3IN;
  assign lut_ofs[GLL_T_LOWER_B_3IN] = GLL_OFS_LOWER_B_3IN;
  assign lut_ofs[GLL_T_LOWER_A_3IN] = GLL_OFS_LOWER_A_3IN;
  assign lut_ofs[GLL_T_LOWER_B_DUAL_FIRST] = GLL_OFS_LOWER_B_DUAL_FIRST;
  assign lut_ofs[GLL_T_LOWER_B_DUAL_SECOND] = GLL_OFS_LOWER_B_DUAL_SECOND;

  // Index pins of each table; both lower-B dual tables share the same three pins.
  assign lut_sel[GLL_T_UPPER_A_3IN] = io_in[GLL_PIN_UPPER_A_IN +: GLL_SEL_W];
  assign lut_sel[GLL_T_LOWER_B_3IN] = io_in[GLL_PIN_LOWER_B_IN +: GLL_SEL_W];
  assign lut_sel[GLL_T_LOWER_A_3IN] = io_in[GLL_PIN_LOWER_A_IN +: GLL_SEL_W];
  assign lut_sel[GLL_T_LOWER_B_DUAL_FIRST] = io_in[GLL_PIN_LOWER_B_IN +: GLL_SEL_W];
  assign lut_sel[GLL_T_LOWER_B_DUAL_SECOND] = io_in[GLL_PIN_LOWER_B_IN +: GLL_SEL_W];

  // Mode fields are plain inputs; the cast only names their codes.
  assign upa_mode = gll_mode_e'(upper_a_logic_mode);
  assign lwa_mode = gll_mode_e'(lower_a_logic_mode);
  assign lwb_mode = gll_mode_e'(lower_b_logic_mode);

  // A table is live only while its half-bank sits in the matching lookup mode.
  assign lut_live[GLL_T_UPPER_A_3IN] = (upa_mode == GLL_MODE_3TO1);
  assign lut_live[GLL_T_LOWER_B_3IN] = (lwb_mode == GLL_MODE_3TO1);
  assign lut_live[GLL_T_LOWER_A_3IN] = (lwa_mode == GLL_MODE_3TO1);
  assign lut_live[GLL_T_LOWER_B_DUAL_FIRST] = (lwb_mode == GLL_MODE_3TO2);
  assign lut_live[GLL_T_LOWER_B_DUAL_SECOND] = (lwb_mode == GLL_MODE_3TO2);

  // One lookup per table, each fed from the live pins.
  for (genvar gi = 0; gi < GLL_NUM_LUT; gi++) begin : g_lut
    assign hit[gi] = (reg_addr == lut_ofs[gi]);
    gll_lut3 u_lut (
      .table_bits(st_q.lut[gi]),
      .sel(lut_sel[gi]),
      .result(lut_bit[gi])
    );
  end

  // Unmapped reads answer with a fixed word; mapped reads take the current table.
  always_comb begin
    rd_word = GLL_RDATA_UNMAPPED;
    for (int i = 0; i < GLL_NUM_LUT; i++) begin
      if (hit[i]) begin
        rd_word = st_q.lut[i];
      end
    end
  end

  always_comb begin
    st_d = st_q;
    // A read captures the contents before a write in the same cycle lands.
    st_d.rvalid = reg_rd_en;
    if (reg_rd_en) begin
      st_d.rdata = rd_word;
    end
    // Writes to an address without a table are dropped.
    for (int i = 0; i < GLL_NUM_LUT; i++) begin
      if (reg_wr_en && hit[i]) begin
        st_d.lut[i] = reg_wdata;
      end
    end

    // Pins are recomputed every cycle from the inputs and modes.
    st_d.pin_out = '0;
    st_d.pin_en = '0;
    // Upper-A 3-to-1 table on pin 7.
    if (lut_live[GLL_T_UPPER_A_3IN]) begin
      st_d.pin_out[GLL_PIN_UPPER_A_OUT] = lut_bit[GLL_T_UPPER_A_3IN];
      st_d.pin_en[GLL_PIN_UPPER_A_OUT] = 1'b1;
    end
    // Lower-A 3-to-1 table on pin 3.
    if (lut_live[GLL_T_LOWER_A_3IN]) begin
      st_d.pin_out[GLL_PIN_LOWER_A_OUT] = lut_bit[GLL_T_LOWER_A_3IN];
      st_d.pin_en[GLL_PIN_LOWER_A_OUT] = 1'b1;
    end
    unique case (lwb_mode)
      // Lower-B 3-to-1 table on pin 11.
      GLL_MODE_3TO1: begin
        st_d.pin_out[GLL_PIN_LOWER_B_OUT] = lut_bit[GLL_T_LOWER_B_3IN];
        st_d.pin_en[GLL_PIN_LOWER_B_OUT] = 1'b1;
      end
      // Lower-B dual tables on pins 11 and 12.
      GLL_MODE_3TO2: begin
        st_d.pin_out[GLL_PIN_LOWER_B_OUT] = lut_bit[GLL_T_LOWER_B_DUAL_FIRST];
        st_d.pin_en[GLL_PIN_LOWER_B_OUT] = 1'b1;
        st_d.pin_out[GLL_PIN_LOWER_B_OUT2] = lut_bit[GLL_T_LOWER_B_DUAL_SECOND];
        st_d.pin_en[GLL_PIN_LOWER_B_OUT2] = 1'b1;
      end
      // No table here for these modes; pins 11 and 12 are left to the port.
      GLL_MODE_OFF, GLL_MODE_2TO1: begin
      end
    endcase
  end

  // One register stage for all state; tables come out of reset at zero.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_q.lut <= {GLL_NUM_LUT{GLL_LUT_RESET}};
      st_q.rdata <= GLL_RDATA_UNMAPPED;
      st_q.rvalid <= 1'b0;
      st_q.pin_out <= '0;
      st_q.pin_en <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Every output comes straight from the state register.
  assign reg_rdata = st_q.rdata;
  assign reg_rvalid = st_q.rvalid;
  assign io_lut_out = st_q.pin_out;
  assign io_lut_en = st_q.pin_en;

endmodule

// file: hw/gll_lut3.sv
// Three-input lookup: picks one bit of an eight-bit truth table.
module gll_lut3 (
  // Table contents.
  input wire logic [7:0] table_bits,
  // Input pattern.
  input wire logic [2:0] sel,
  // Selected bit.
  output logic result
);

  // Bit n of the table answers input pattern n.
  assign result = table_bits[sel];

endmodule

// file: hw/gll_pkg.sv
// Constants shared by the GPIO lookup logic block.
package gll_pkg;

  localparam int unsigned GLL_ADDR_W = 8;
  localparam int unsigned GLL_DATA_W = 8;
  localparam int unsigned GLL_IO_W = 16;
  localparam int unsigned GLL_NUM_LUT = 5;
  localparam int unsigned GLL_SEL_W = 3;

  localparam logic [GLL_ADDR_W-1:0] GLL_OFS_UPPER_A_3IN = 8'h25;
  localparam logic [GLL_ADDR_W-1:0] GLL_OFS_LOWER_B_3IN = 8'h26;
  localparam logic [GLL_ADDR_W-1:0] GLL_OFS_LOWER_A_3IN = 8'h27;
  localparam logic [GLL_ADDR_W-1:0] GLL_OFS_LOWER_B_DUAL_FIRST = 8'h28;
  localparam logic [GLL_ADDR_W-1:0] GLL_OFS_LOWER_B_DUAL_SECOND = 8'h2A;

  localparam logic [GLL_DATA_W-1:0] GLL_LUT_RESET = 8'h00;
  localparam logic [GLL_DATA_W-1:0] GLL_RDATA_UNMAPPED = 8'h00;

  // Logic mode of a half-bank.
  typedef enum logic [1:0] {
    GLL_MODE_OFF = 2'b00,
    GLL_MODE_2TO1 = 2'b01,
    GLL_MODE_3TO1 = 2'b10,
    GLL_MODE_3TO2 = 2'b11
  } gll_mode_e;

  // Table index order inside the state array.
  localparam int unsigned GLL_T_UPPER_A_3IN = 0;
  localparam int unsigned GLL_T_LOWER_B_3IN = 1;
  localparam int unsigned GLL_T_LOWER_A_3IN = 2;
  localparam int unsigned GLL_T_LOWER_B_DUAL_FIRST = 3;
  localparam int unsigned GLL_T_LOWER_B_DUAL_SECOND = 4;

  // Pin positions: lowest pin of each three-pin index group and the driven pins.
  localparam int unsigned GLL_PIN_UPPER_A_IN = 4;
  localparam int unsigned GLL_PIN_LOWER_A_IN = 0;
  localparam int unsigned GLL_PIN_LOWER_B_IN = 8;
  localparam int unsigned GLL_PIN_UPPER_A_OUT = 7;
  localparam int unsigned GLL_PIN_LOWER_A_OUT = 3;
  localparam int unsigned GLL_PIN_LOWER_B_OUT = 11;
  localparam int unsigned GLL_PIN_LOWER_B_OUT2 = 12;

endpackage

// file: verification/gll_lookup_logic_props.sv
// Port assertions for the GPIO lookup logic block.
module gll_lookup_logic_props (
  // Clock, reset and mode selects.
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [1:0] upper_a_logic_mode,
  input wire logic [1:0] lower_a_logic_mode,
  input wire logic [1:0] lower_b_logic_mode,
  // Pin drive.
  input wire logic [15:0] io_lut_out,
  input wire logic [15:0] io_lut_en
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  upa_drive_a: assert property (upper_a_logic_mode == 2'h2 |=> io_lut_en[7])
    else $error("pin 7 not driven");
  lwa_drive_a: assert property (lower_a_logic_mode == 2'h2 |=> io_lut_en[3])
    else $error("pin 3 not driven");
  lwb_single_a: assert property (lower_b_logic_mode == 2'h2 |=> io_lut_en[12:11] == 2'h1)
    else $error("lower B single drive wrong");
  lwb_dual_a: assert property (lower_b_logic_mode == 2'h3 |=> io_lut_en[12:11] == 2'h3)
    else $error("lower B dual drive wrong");
  upa_release_a: assert property (upper_a_logic_mode != 2'h2 |=> !io_lut_en[7])
    else $error("pin 7 driven out of mode");
  lwa_release_a: assert property (lower_a_logic_mode != 2'h2 |=> !io_lut_en[3])
    else $error("pin 3 driven out of mode");
  lwb_release_a: assert property (!lower_b_logic_mode[1] |=> io_lut_en[12:11] == 2'h0)
    else $error("lower B driven out of mode");
  undriven_low_a: assert property ((io_lut_out & ~io_lut_en) == 16'h0)
    else $error("undriven pin output high");
  cover property (io_lut_out[7]);
  cover property (io_lut_out[3]);
  cover property (io_lut_en[12] && io_lut_out[12]);
endmodule
bind gll_lookup_logic gll_lookup_logic_props gll_lookup_logic_props_inst (.*);

// file: verification/gll_pin_model.sv
// Far-side pins: outside drivers, overridden where the block drives.
module gll_pin_model (
  input wire logic [15:0] ext_drv,
  input wire logic [15:0] io_lut_out,
  input wire logic [15:0] io_lut_en,
  output logic [15:0] io_in
);
  timeunit 1ns;
  timeprecision 1ps;
  assign io_in = (ext_drv & ~io_lut_en) | (io_lut_out & io_lut_en);
endmodule

// file: verification/tb_gll_lookup_logic.sv
// Testbench for the GPIO lookup logic block.
module tb_gll_lookup_logic;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'h0, rstn = 1'h0, reg_wr_en = 1'h0, reg_rd_en = 1'h0, reg_rvalid;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic [1:0] upper_a_logic_mode = 2'h0, lower_a_logic_mode = 2'h0, lower_b_logic_mode = 2'h0;
  logic [15:0] io_in, io_lut_out, io_lut_en, ext_drv = 16'h0;
  int failures = 0, comparisons = 0;
  always #5 clk_sys = ~clk_sys;
  gll_lookup_logic gll_lookup_logic_inst (.*);
  gll_pin_model gll_pin_model_inst (.*);
  task automatic chk(string n, logic [15:0] e, logic [15:0] s);
    comparisons++;
    if (e !== s) begin
      failures++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic step(int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    reg_wr_en = 1'h1;
    reg_addr = a;
    reg_wdata = d;
    step(1);
    reg_wr_en = 1'h0;
    step(1);
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    reg_rd_en = 1'h1;
    reg_addr = a;
    step(1);
    chk("rdata", {8'h01, e}, {7'h0, reg_rvalid, reg_rdata});
    reg_rd_en = 1'h0;
    step(1);
    chk("rvalid drop", {8'h00, e}, {7'h0, reg_rvalid, reg_rdata});
  endtask
  // Walks all eight index patterns and compares the driven pin with the table.
  task automatic sweep(int lo, int op, logic [7:0] t);
    for (int i = 0; i < 8; i++) begin
      ext_drv[lo+:3] = 3'(i);
      step(2);
      chk("lut pin", {15'h0, t[i]}, {15'h0, io_lut_out[op]});
    end
  endtask
  task automatic t_reset();
    for (int a = 8'h25; a < 8'h2D; a++) rd(8'(a), 8'h00);
    chk("en", 16'h0, io_lut_en);
  endtask
  task automatic t_upper_a();
    wr(8'h25, 8'hA6);
    rd(8'h25, 8'hA6);
    upper_a_logic_mode = 2'h2;
    sweep(4, 7, 8'hA6);
    chk("en", 16'h0080, io_lut_en);
    upper_a_logic_mode = 2'h0;
    step(2);
    chk("en", 16'h0, io_lut_en);
  endtask
  task automatic t_lower_a();
    wr(8'h27, 8'h3C);
    lower_a_logic_mode = 2'h2;
    sweep(0, 3, 8'h3C);
    lower_a_logic_mode = 2'h0;
  endtask
  task automatic t_lower_b();
    wr(8'h26, 8'h96);
    wr(8'h28, 8'h69);
    wr(8'h2A, 8'hF0);
    lower_b_logic_mode = 2'h2;
    sweep(8, 11, 8'h96);
    lower_b_logic_mode = 2'h3;
    sweep(8, 11, 8'h69);
    sweep(8, 12, 8'hF0);
    chk("en", 16'h1800, io_lut_en);
  endtask
  task automatic t_idle_modes();
    wr(8'h29, 8'hFF);
    rd(8'h29, 8'h00);
    upper_a_logic_mode = 2'h1;
    lower_a_logic_mode = 2'h3;
    lower_b_logic_mode = 2'h1;
    step(2);
    chk("en", 16'h0, io_lut_en);
    upper_a_logic_mode = 2'h3;
    lower_a_logic_mode = 2'h1;
    lower_b_logic_mode = 2'h0;
    step(2);
    chk("en", 16'h0, io_lut_en);
    upper_a_logic_mode = 2'h0;
    lower_a_logic_mode = 2'h0;
  endtask
  task automatic t_reset_mid();
    rstn = 1'h0;
    step(2);
    chk("en", 16'h0, io_lut_en);
    rstn = 1'h1;
    wr(8'h26, 8'h55);
    step(2);
    rd(8'h25, 8'h00);
    rd(8'h26, 8'h00);
    lower_a_logic_mode = 2'h2;
    step(2);
    chk("out", 16'h0, io_lut_out);
    chk("en", 16'h0008, io_lut_en);
    lower_a_logic_mode = 2'h0;
  endtask
  task automatic end_of_test();
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    step(20);
    rstn = 1'h1;
    step(3);
    t_reset();
    t_upper_a();
    t_lower_a();
    t_lower_b();
    t_idle_modes();
    t_reset_mid();
    end_of_test();
  end
  initial begin
    #20000;
    failures++;
    end_of_test();
  end
endmodule
